// [pkg/eiv_consts.vh]
// Constants for the external request enable, sense and vectoring block.
`ifndef EIV_CONSTS_VH
`define EIV_CONSTS_VH
// ****************************************************************
// Register byte offsets on the APB.
// ****************************************************************
`define EIV_OFS_ENABLE 6'h00
`define EIV_OFS_SENSE 6'h04
`define EIV_OFS_STATUS 6'h08
`define EIV_OFS_SYSCTL 6'h0C
`define EIV_OFS_PRIA 6'h10
`define EIV_OFS_PRIB 6'h14
// ****************************************************************
// Reset values and field positions.
// ****************************************************************
`define EIV_RST_BYTE 8'h00
`define EIV_PIN_MSB 5
`define EIV_PIN_COUNT 6
`define EIV_INT_COUNT 27
`define EIV_SRC_COUNT 33
`define EIV_SYSCTL_NMI_EDGE 0
`define EIV_SYSCTL_MASK 8'h01
`define EIV_STATUS_MASK 8'h3F
// ****************************************************************
// Vector numbers of the sources.
// ****************************************************************
`define EIV_VEC_NMI 6'h07
`define EIV_VEC_PIN0 6'h0C
`define EIV_VEC_WDT 6'h14
`define EIV_VEC_ADC 6'h17
`define EIV_VEC_TMR0 6'h18
`define EIV_VEC_TMR1 6'h1C
`define EIV_VEC_TMR2 6'h20
`define EIV_VEC_TMR8A 6'h24
`define EIV_VEC_SER0 6'h34
// ****************************************************************
// First source index of each group in the request vector.
// ****************************************************************
`define EIV_IDX_WDT 6'd6
`define EIV_IDX_ADC 6'd7
`define EIV_IDX_TMR0 6'd8
`define EIV_IDX_TMR1 6'd11
`define EIV_IDX_TMR2 6'd14
`define EIV_IDX_TMR8A 6'd17
`define EIV_IDX_TMR8B 6'd21
`define EIV_IDX_SER0 6'd25
`define EIV_IDX_SER1 6'd29
// ****************************************************************
// Priority bit positions in the two priority registers.
// ****************************************************************
`define EIV_PA_PIN0 7
`define EIV_PA_PIN1 6
`define EIV_PA_PIN23 5
`define EIV_PA_PIN45 4
`define EIV_PA_WDT_ADC 3
`define EIV_PA_TMR0 2
`define EIV_PA_TMR1 1
`define EIV_PA_TMR2 0
`define EIV_PB_TMR8A 7
`define EIV_PB_TMR8B 6
`define EIV_PB_SER0 3
`define EIV_PB_SER1 2
`endif

// [logic/eiv_pin_sync.v]
// Three-stage pin synchroniser with filtered level and edge pulses.
`timescale 1ns/100ps
`default_nettype none
module eiv_pin_sync #(
  parameter RST_VAL = 1'b1
) (
  input wire clk,
  input wire rst,
  input wire pin,
  output reg level_q,
  output reg fall_q,
  output reg rise_q
);
  reg s1_q;
  reg s2_q;
  reg s3_q;
  // ****************************************************************
  // Synchroniser chain and agreement filter.
  // ****************************************************************
  // A change counts only once the second and third stages agree.
  // synchronise and edge
  always @(posedge clk) begin
    if (rst) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
      level_q <= RST_VAL;
      fall_q <= 1'b0;
      rise_q <= 1'b0;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      fall_q <= 1'b0;
      rise_q <= 1'b0;
      if (s2_q == s3_q) begin
        level_q <= s3_q;
        fall_q <= level_q & ~s3_q; // High sample then low sample.
        rise_q <= ~level_q & s3_q;
      end
    end
  end
endmodule // eiv_pin_sync
`default_nettype wire

// [logic/eiv_top.v]
// External request front end with enable, sense, priority and vectoring.
//
// Overview of operation
// - Enable register eight bits, clears to zero
// - Enable bits seven and six are storage
// - Enable bits five to zero gate pins
// - Sense register eight bits, clears to zero
// - Sense bits seven and six are storage
// - Sense bit zero level, one falling edge
// - Seven external sources; four may wake
// - Nonmaskable request ranks above all others
// - Control bit picks nonmaskable edge polarity
// - Nonmaskable request uses vector seven
// - Pins zero to five use vectors 12-17
// - Pin state sensed regardless of direction
// - Twenty-seven internal peripheral request sources accepted
// - Peripheral enables; priority set by two registers
// - Smaller vector wins by default
// - Pin priority bits in priority register A
// - Vector address is number times four/two
// - Pin flag clears by write zero after one
// - Disabled requests are never forwarded
`timescale 1ns/100ps
`default_nettype none
`include "eiv_consts.vh"
module eiv_top (
  input wire SYS_CLK,
  input wire RST,
  input wire HW_STANDBY,
  input wire MODE_ADVANCED,
  input wire [5:0] IRQ_PIN_N,
  input wire NMI_PIN,
  input wire [26:0] INT_REQ,
  input wire [26:0] INT_EN,
  input wire CPU_ACK,
  input wire [5:0] CPU_ACK_VECTOR,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [7:0] PADDR,
  input wire [31:0] PWDATA,
  output reg [31:0] PRDATA,
  output reg PREADY,
  output reg PSLVERR,
  output reg REQ_VALID,
  output reg [5:0] REQ_VECTOR,
  output reg REQ_LEVEL,
  output reg [15:0] REQ_ADDR,
  output reg NMI_PENDING,
  output reg STANDBY_WAKE
);
  // ****************************************************************
  // Functions: source vector numbers and priority levels.
  // ****************************************************************
  // Source index order: pins 0-5, then internal sources in vector order.
  // source vector map
  function [5:0] src_vec;
    input [5:0] idx;
    begin
      if (idx < `EIV_IDX_WDT)
        src_vec = `EIV_VEC_PIN0 + idx;
      else if (idx == `EIV_IDX_WDT)
        src_vec = `EIV_VEC_WDT;
      else if (idx == `EIV_IDX_ADC)
        src_vec = `EIV_VEC_ADC;
      else if (idx < `EIV_IDX_TMR1)
        src_vec = `EIV_VEC_TMR0 + (idx - `EIV_IDX_TMR0);
      else if (idx < `EIV_IDX_TMR2)
        src_vec = `EIV_VEC_TMR1 + (idx - `EIV_IDX_TMR1);
      else if (idx < `EIV_IDX_TMR8A)
        src_vec = `EIV_VEC_TMR2 + (idx - `EIV_IDX_TMR2);
      else if (idx < `EIV_IDX_SER0)
        src_vec = `EIV_VEC_TMR8A + (idx - `EIV_IDX_TMR8A);
      else
        src_vec = `EIV_VEC_SER0 + (idx - `EIV_IDX_SER0);
    end
  endfunction

  // Pins 2/3 and 4/5 share a bit; grouped peripherals share one too.
  // source priority bits
  function src_lvl;
    input [5:0] idx;
    input [7:0] pa;
    input [7:0] pb;
    begin
      case (idx)
        6'd0: src_lvl = pa[`EIV_PA_PIN0];
        6'd1: src_lvl = pa[`EIV_PA_PIN1];
        6'd2, 6'd3: src_lvl = pa[`EIV_PA_PIN23];
        6'd4, 6'd5: src_lvl = pa[`EIV_PA_PIN45];
        default: begin
          if (idx < `EIV_IDX_TMR0)
            src_lvl = pa[`EIV_PA_WDT_ADC];
          else if (idx < `EIV_IDX_TMR1)
            src_lvl = pa[`EIV_PA_TMR0];
          else if (idx < `EIV_IDX_TMR2)
            src_lvl = pa[`EIV_PA_TMR1];
          else if (idx < `EIV_IDX_TMR8A)
            src_lvl = pa[`EIV_PA_TMR2];
          else if (idx < `EIV_IDX_TMR8B)
            src_lvl = pb[`EIV_PB_TMR8A];
          else if (idx < `EIV_IDX_SER0)
            src_lvl = pb[`EIV_PB_TMR8B];
          else if (idx < `EIV_IDX_SER1)
            src_lvl = pb[`EIV_PB_SER0];
          else
            src_lvl = pb[`EIV_PB_SER1];
        end
      endcase
    end
  endfunction

  // ****************************************************************
  // Declarations.
  // ****************************************************************
  reg [7:0] enable_q;
  reg [7:0] sense_q;
  reg [5:0] status_q;
  reg [5:0] status_d;
  reg [5:0] armed_q;
  reg [7:0] sysctl_q;
  reg [7:0] pria_q;
  reg [7:0] prib_q;
  reg nmi_flag_q;
  reg [31:0] rdata_d;
  reg rd_err_d;
  reg [32:0] req_all;
  reg win_found;
  reg win_lvl;
  reg [5:0] win_idx;
  reg [5:0] win_vec;
  integer i;
  integer j;
  wire [5:0] pin_level;
  wire [5:0] pin_fall;
  wire nmi_fall;
  wire nmi_rise;
  wire clr_all;
  wire acc_cyc;
  wire done_cyc;
  wire wr_done;
  wire rd_done;
  wire nmi_edge;
  wire ack_nmi;
  wire [5:0] ack_pin;
  wire [5:0] pin_vec_base;

  // Hardware standby clears the software registers, flags and outputs as reset does; synchronisers and bus answer clear on reset only.
  assign clr_all = RST | HW_STANDBY;

  // ****************************************************************
  // Pin input synchronisers.
  // ****************************************************************
  // Pins are sampled directly, so the port direction does not matter.
  // direction independent
  genvar g;
  generate
    for (g = 0; g < `EIV_PIN_COUNT; g = g + 1) begin : g_pin
      eiv_pin_sync #(.RST_VAL(1'b1)) u_sync (
        .clk(SYS_CLK),
        .rst(RST),
        .pin(IRQ_PIN_N[g]),
        .level_q(pin_level[g]),
        .fall_q(pin_fall[g]),
        .rise_q()
      );
    end
  endgenerate

  // Nonmaskable input uses the same filter.
  eiv_pin_sync #(.RST_VAL(1'b1)) u_nmi_sync (
    .clk(SYS_CLK),
    .rst(RST),
    .pin(NMI_PIN),
    .level_q(),
    .fall_q(nmi_fall),
    .rise_q(nmi_rise)
  );

  // ****************************************************************
  // APB handshake: one wait state, answer registered.
  // ****************************************************************
  assign acc_cyc = PSEL & PENABLE & ~PREADY;
  assign done_cyc = PSEL & PENABLE & PREADY;
  assign wr_done = done_cyc & PWRITE & ~PSLVERR;
  assign rd_done = done_cyc & ~PWRITE & ~PSLVERR;

  // Read mux; unmapped addresses answer with an error and zero data.
  always @* begin
    rdata_d = 32'h00000000;
    rd_err_d = 1'b0;
    case (PADDR[5:0])
      `EIV_OFS_ENABLE: rdata_d[7:0] = enable_q;
      `EIV_OFS_SENSE: rdata_d[7:0] = sense_q;
      `EIV_OFS_STATUS: rdata_d[5:0] = status_q;
      `EIV_OFS_SYSCTL: rdata_d[7:0] = sysctl_q;
      `EIV_OFS_PRIA: rdata_d[7:0] = pria_q;
      `EIV_OFS_PRIB: rdata_d[7:0] = prib_q;
      default: rd_err_d = 1'b1;
    endcase
    if (PADDR[7:6] != 2'b00)
      rd_err_d = 1'b1;
  end

  // Ready and read data are captured in the first access cycle.
  always @(posedge SYS_CLK) begin
    if (RST) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h00000000;
    end else begin
      PREADY <= acc_cyc;
      PSLVERR <= acc_cyc & rd_err_d;
      if (acc_cyc && !PWRITE && !rd_err_d)
        PRDATA <= rdata_d;
      else if (acc_cyc)
        PRDATA <= 32'h00000000;
    end
  end

  // ****************************************************************
  // Software registers.
  // ****************************************************************
  // Full bytes are stored except control, which keeps bit zero only; upper enable and sense bits steer nothing.
  // clear on reset
  always @(posedge SYS_CLK) begin
    if (clr_all) begin
      enable_q <= `EIV_RST_BYTE;
      sense_q <= `EIV_RST_BYTE;
      sysctl_q <= `EIV_RST_BYTE;
      pria_q <= `EIV_RST_BYTE;
      prib_q <= `EIV_RST_BYTE;
    end else if (wr_done) begin
      case (PADDR[5:0])
        `EIV_OFS_ENABLE: enable_q <= PWDATA[7:0];
        `EIV_OFS_SENSE: sense_q <= PWDATA[7:0];
        `EIV_OFS_SYSCTL: sysctl_q <= PWDATA[7:0] & `EIV_SYSCTL_MASK;
        `EIV_OFS_PRIA: pria_q <= PWDATA[7:0];
        `EIV_OFS_PRIB: prib_q <= PWDATA[7:0];
        default: sysctl_q <= sysctl_q;
      endcase
    end
  end

  // ****************************************************************
  // Pin pending flags.
  // ****************************************************************
  assign pin_vec_base = `EIV_VEC_PIN0;
  assign ack_nmi = CPU_ACK & (CPU_ACK_VECTOR == `EIV_VEC_NMI);
  generate
    for (g = 0; g < `EIV_PIN_COUNT; g = g + 1) begin : g_ack
      assign ack_pin[g] = CPU_ACK & (CPU_ACK_VECTOR == pin_vec_base + g);
    end
  endgenerate

  // Clear by software write of zero after a read of one, or by servicing.
  // A set in the same cycle as a clear wins.
  // level or falling edge
  always @* begin
    status_d = status_q;
    for (i = 0; i < `EIV_PIN_COUNT; i = i + 1) begin
      if (wr_done && PADDR[5:0] == `EIV_OFS_STATUS && armed_q[i] && !PWDATA[i])
        status_d[i] = 1'b0;
      if (ack_pin[i] && (sense_q[i] || pin_level[i]))
        status_d[i] = 1'b0;
      if (sense_q[i] ? pin_fall[i] : !pin_level[i])
        status_d[i] = 1'b1;
    end
  end

  // Arming records which flags were read as one since the last write.
  always @(posedge SYS_CLK) begin
    if (clr_all) begin
      status_q <= 6'h00;
      armed_q <= 6'h00;
    end else begin
      status_q <= status_d;
      if (wr_done && PADDR[5:0] == `EIV_OFS_STATUS)
        armed_q <= 6'h00;
      else if (rd_done && PADDR[5:0] == `EIV_OFS_STATUS)
        armed_q <= armed_q | status_q;
      else
        armed_q <= armed_q & status_q;
    end
  end

  // ****************************************************************
  // Nonmaskable request.
  // ****************************************************************
  // edge polarity select
  assign nmi_edge = sysctl_q[`EIV_SYSCTL_NMI_EDGE] ? nmi_rise : nmi_fall;

  // Pending until serviced; a new edge in the ack cycle keeps it set.
  always @(posedge SYS_CLK) begin
    if (clr_all)
      nmi_flag_q <= 1'b0;
    else if (nmi_edge)
      nmi_flag_q <= 1'b1;
    else if (ack_nmi)
      nmi_flag_q <= 1'b0;
  end

  // ****************************************************************
  // Arbitration.
  // ****************************************************************
  // Pins pass only when enabled; internal requests only with own enable.
  // gate by enable
  always @* begin
    req_all = {INT_REQ & INT_EN, status_q & enable_q[`EIV_PIN_MSB:0]};
  end

  // Level one first, then level zero; in each, the lowest index wins.
  // smaller vector wins
  always @* begin
    win_found = 1'b0;
    win_lvl = 1'b0;
    win_idx = 6'd0;
    for (j = `EIV_SRC_COUNT - 1; j >= 0; j = j - 1) begin
      if (req_all[j] && !src_lvl(j[5:0], pria_q, prib_q) && !win_lvl) begin
        win_found = 1'b1;
        win_idx = j[5:0];
      end
    end
    for (j = `EIV_SRC_COUNT - 1; j >= 0; j = j - 1) begin
      if (req_all[j] && src_lvl(j[5:0], pria_q, prib_q)) begin
        win_found = 1'b1;
        win_lvl = 1'b1;
        win_idx = j[5:0];
      end
    end
    win_vec = src_vec(win_idx);
  end

  // ****************************************************************
  // Request outputs to the CPU core.
  // ****************************************************************
  // Nonmaskable always overrides, whatever the CPU masks are.
  // nonmaskable first
  always @(posedge SYS_CLK) begin
    if (clr_all) begin
      REQ_VALID <= 1'b0;
      REQ_VECTOR <= 6'h00;
      REQ_LEVEL <= 1'b0;
      REQ_ADDR <= 16'h0000;
      NMI_PENDING <= 1'b0;
    end else begin
      NMI_PENDING <= nmi_flag_q;
      if (nmi_flag_q) begin
        REQ_VALID <= 1'b1;
        REQ_VECTOR <= `EIV_VEC_NMI;
        REQ_LEVEL <= 1'b1;
        REQ_ADDR <= MODE_ADVANCED ? {8'h00, `EIV_VEC_NMI, 2'b00} :
                                    {9'h000, `EIV_VEC_NMI, 1'b0};
      end else begin
        REQ_VALID <= win_found;
        REQ_VECTOR <= win_found ? win_vec : 6'h00;
        REQ_LEVEL <= win_found & win_lvl;
        REQ_ADDR <= !win_found ? 16'h0000 :
                    MODE_ADVANCED ? {8'h00, win_vec, 2'b00} : {9'h000, win_vec, 1'b0};
      end
    end
  end

  // ****************************************************************
  // Standby wake.
  // ****************************************************************
  // Only the nonmaskable input and enabled pins 2, 1 and 0 wake the part.
  // wake sources
  always @(posedge SYS_CLK) begin
    if (clr_all)
      STANDBY_WAKE <= 1'b0;
    else
      STANDBY_WAKE <= nmi_flag_q | (|(status_q[2:0] & enable_q[2:0]));
  end
endmodule // eiv_top
`default_nettype wire

// [dv/eiv_top_monitor.sv]
// Concurrent checks on the ports of the external request front end.
`timescale 1ns/100ps
`default_nettype none
`include "eiv_consts.vh"
module eiv_top_monitor (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic HW_STANDBY,
  input wire logic MODE_ADVANCED,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic REQ_VALID,
  input wire logic [5:0] REQ_VECTOR,
  input wire logic [15:0] REQ_ADDR,
  input wire logic NMI_PENDING,
  input wire logic STANDBY_WAKE
);
  // ****************************************************************
  // Bus timing, register width, vectoring and standby checks.
  // ****************************************************************
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  a_ready_one_wait: assert property (
    PSEL && !PENABLE |=> !PREADY ##1 PREADY ##1 !PREADY) else $error("Bad ready timing.");
  a_rdata_byte_wide: assert property (
    PREADY && !PWRITE |-> PRDATA[31:8] == 24'h000000) else $error("Read data too wide.");
  a_addr_adv_mode: assert property (
    REQ_VALID && MODE_ADVANCED && $past(MODE_ADVANCED) && $past(MODE_ADVANCED, 2)
    |-> REQ_ADDR == {8'h00, REQ_VECTOR, 2'b00}) else $error("Bad advanced address.");
  a_addr_norm_mode: assert property (
    REQ_VALID && !MODE_ADVANCED && !$past(MODE_ADVANCED) && !$past(MODE_ADVANCED, 2)
    |-> REQ_ADDR == {9'h000, REQ_VECTOR, 1'b0}) else $error("Bad normal address.");
  a_nmi_wins_seven: assert property (
    NMI_PENDING |-> REQ_VALID && REQ_VECTOR == `EIV_VEC_NMI) else $error("Nonmaskable lost.");
  a_standby_clears: assert property (
    HW_STANDBY |=> !REQ_VALID && !NMI_PENDING && !STANDBY_WAKE) else $error("Standby kept.");
  a_wake_on_nmi: assert property (
    NMI_PENDING |-> STANDBY_WAKE) else $error("No wake on nonmaskable.");
  a_wake_needs_req: assert property (
    STANDBY_WAKE |-> REQ_VALID) else $error("Wake without request.");
  a_idle_vector: assert property (
    !REQ_VALID |-> REQ_VECTOR == 6'h00) else $error("Vector without request.");
  c_nmi_seen: cover property (NMI_PENDING);
  c_normal_req: cover property (REQ_VALID && !MODE_ADVANCED);
  c_write_done: cover property (PREADY && PWRITE);
endmodule // eiv_top_monitor
bind eiv_top eiv_top_monitor u_eiv_top_monitor (.SYS_CLK(SYS_CLK), .RST(RST),
  .HW_STANDBY(HW_STANDBY), .MODE_ADVANCED(MODE_ADVANCED), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PRDATA(PRDATA), .PREADY(PREADY), .REQ_VALID(REQ_VALID),
  .REQ_VECTOR(REQ_VECTOR), .REQ_ADDR(REQ_ADDR), .NMI_PENDING(NMI_PENDING),
  .STANDBY_WAKE(STANDBY_WAKE));
`default_nettype wire

// [dv/eiv_cpu_model.sv]
// Behavioural core that accepts the forwarded request after a delay.
`timescale 1ns/100ps
`default_nettype none
module eiv_cpu_model #(
  parameter int DELAY = 2
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ack_on,
  input wire logic req_valid,
  input wire logic [5:0] req_vector,
  output logic cpu_ack,
  output logic [5:0] cpu_ack_vector
);
  int cnt_q;
  always @(posedge clk) begin
    cpu_ack <= 1'b0;
    cpu_ack_vector <= ~req_vector; // Idle vector is never a live value.
    if (rst || !ack_on || !req_valid) begin
      cnt_q <= 0;
    end else if (cnt_q == DELAY) begin
      cpu_ack <= 1'b1;
      cpu_ack_vector <= req_vector;
      cnt_q <= -4; // Hold off while the cleared flag reaches the outputs.
    end else begin
      cnt_q <= cnt_q + 1;
    end
  end
endmodule // eiv_cpu_model
`default_nettype wire

// [dv/eiv_top_bench.sv]
// Self-checking bench for the external request front end.
`timescale 1ns/100ps
`default_nettype none
`include "eiv_consts.vh"
module eiv_top_bench;
  logic SYS_CLK, RST, HW_STANDBY, MODE_ADVANCED, NMI_PIN, PSEL, PENABLE, PWRITE, ack_on, er;
  logic PREADY, PSLVERR, REQ_VALID, REQ_LEVEL, NMI_PENDING, STANDBY_WAKE, CPU_ACK;
  logic [5:0] IRQ_PIN_N, REQ_VECTOR, CPU_ACK_VECTOR;
  logic [26:0] INT_REQ, INT_EN;
  logic [7:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rd;
  logic [15:0] REQ_ADDR;
  int num_errors = 0;
  int tests_run = 0;
  localparam logic [7:0] A_EN = {2'b00, `EIV_OFS_ENABLE};
  localparam logic [7:0] A_SC = {2'b00, `EIV_OFS_SENSE};
  localparam logic [7:0] A_ST = {2'b00, `EIV_OFS_STATUS};
  localparam logic [7:0] A_SY = {2'b00, `EIV_OFS_SYSCTL};
  localparam logic [7:0] A_PA = {2'b00, `EIV_OFS_PRIA};
  localparam logic [7:0] A_PB = {2'b00, `EIV_OFS_PRIB};
  eiv_top u_eiv_top (.SYS_CLK(SYS_CLK), .RST(RST), .HW_STANDBY(HW_STANDBY),
    .MODE_ADVANCED(MODE_ADVANCED), .IRQ_PIN_N(IRQ_PIN_N), .NMI_PIN(NMI_PIN),
    .INT_REQ(INT_REQ), .INT_EN(INT_EN), .CPU_ACK(CPU_ACK), .CPU_ACK_VECTOR(CPU_ACK_VECTOR),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .REQ_VALID(REQ_VALID),
    .REQ_VECTOR(REQ_VECTOR), .REQ_LEVEL(REQ_LEVEL), .REQ_ADDR(REQ_ADDR),
    .NMI_PENDING(NMI_PENDING), .STANDBY_WAKE(STANDBY_WAKE));
  eiv_cpu_model u_eiv_cpu_model (.clk(SYS_CLK), .rst(RST), .ack_on(ack_on),
    .req_valid(REQ_VALID), .req_vector(REQ_VECTOR), .cpu_ack(CPU_ACK),
    .cpu_ack_vector(CPU_ACK_VECTOR));
  // ****************************************************************
  // Shared tasks.
  // ****************************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Setup, access until ready is sampled, then release.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge SYS_CLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge SYS_CLK);
    PENABLE <= 1'b1;
    @(posedge SYS_CLK);
    while (PREADY !== 1'b1) begin
      @(posedge SYS_CLK);
    end
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge SYS_CLK);
  endtask
  task automatic wait_req(input logic want);
    int n;
    n = 0;
    @(posedge SYS_CLK);
    while (REQ_VALID !== want && n < 40) begin
      n++;
      @(posedge SYS_CLK);
    end
    if (n >= 40) begin
      num_errors++;
    end
  endtask
  // ****************************************************************
  // Scenarios.
  // ****************************************************************
  task automatic t_regs;
    apb(1'b0, A_EN, 32'h0);
    chk(rd, 32'h00);
    apb(1'b0, A_SC, 32'h0);
    chk(rd, 32'h00);
    wr(A_EN, 32'hFFFFFFC0);
    wr(A_SC, 32'h000000C0);
    apb(1'b0, A_EN, 32'h0);
    chk(rd, 32'hC0);
    apb(1'b0, A_SC, 32'h0);
    chk(rd, 32'hC0);
    HW_STANDBY <= 1'b1;
    cyc(1);
    HW_STANDBY <= 1'b0;
    apb(1'b0, A_EN, 32'h0);
    chk(rd, 32'h00);
    apb(1'b0, A_SC, 32'h0);
    chk(rd, 32'h00);
    apb(1'b0, 8'h40, 32'h0);
    chk(er, 1'b1);
    $display("test regs done");
  endtask
  // Level sensing on pin 0 with the gate shut, then open.
  task automatic t_gate;
    IRQ_PIN_N <= 6'h3E;
    wr(A_EN, 32'hC0);
    cyc(12);
    chk(REQ_VALID, 1'b0);
    wr(A_EN, 32'h01);
    wait_req(1'b1);
    chk(REQ_VECTOR, `EIV_VEC_PIN0);
    chk(REQ_ADDR, 16'h0030);
    MODE_ADVANCED <= 1'b0;
    cyc(3);
    chk(REQ_ADDR, 16'h0018);
    MODE_ADVANCED <= 1'b1;
    ack_on <= 1'b1;
    cyc(20);
    chk(REQ_VALID, 1'b1);
    IRQ_PIN_N <= 6'h3F;
    wait_req(1'b0);
    chk(REQ_VALID, 1'b0);
    ack_on <= 1'b0;
    $display("test gate done");
  endtask
  // Falling edge on each pin in turn, acknowledged by the core.
  task automatic t_edges;
    wr(A_SC, 32'h3F);
    wr(A_EN, 32'h3F);
    ack_on <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      IRQ_PIN_N <= ~(6'h01 << i);
      wait_req(1'b1);
      chk(REQ_VECTOR, `EIV_VEC_PIN0 + i);
      chk(STANDBY_WAKE, i < 3);
      wait_req(1'b0);
      cyc(8);
      chk(REQ_VALID, 1'b0);
      IRQ_PIN_N <= 6'h3F;
      cyc(6);
    end
    ack_on <= 1'b0;
    $display("test edges done");
  endtask
  // Default order, pin priority bits, status clear and internal sources.
  task automatic t_prio;
    IRQ_PIN_N <= 6'h36;
    wait_req(1'b1);
    cyc(2);
    chk(REQ_VECTOR, `EIV_VEC_PIN0);
    wr(A_PA, 32'h01 << `EIV_PA_PIN23);
    cyc(2);
    chk(REQ_VECTOR, `EIV_VEC_PIN0 + 3);
    chk(REQ_LEVEL, 1'b1);
    apb(1'b0, A_PA, 32'h0);
    chk(rd, 32'h20);
    apb(1'b0, A_ST, 32'h0);
    chk(rd, 32'h09);
    wr(A_ST, 32'h0);
    cyc(3);
    chk(REQ_VALID, 1'b0);
    IRQ_PIN_N <= 6'h3F;
    INT_REQ <= 27'h1;
    cyc(4);
    chk(REQ_VALID, 1'b0);
    INT_EN <= 27'h1;
    wait_req(1'b1);
    chk(REQ_VECTOR, `EIV_VEC_WDT);
    chk(REQ_ADDR, 16'h0050);
    INT_REQ <= 27'h80001;
    INT_EN <= 27'h80001;
    cyc(2);
    chk(REQ_VECTOR, `EIV_VEC_WDT);
    wr(A_PB, 32'h01 << `EIV_PB_SER0);
    cyc(2);
    chk(REQ_VECTOR, `EIV_VEC_SER0);
    chk(REQ_LEVEL, 1'b1);
    chk(REQ_ADDR, 16'h00D0);
    INT_REQ <= 27'h0;
    INT_EN <= 27'h0;
    $display("test prio done");
  endtask
  // Nonmaskable request over a level-one pin, then edge polarity.
  task automatic t_nmi;
    wr(A_SC, 32'h00);
    wr(A_PA, 32'h80);
    wr(A_SY, 32'h00);
    IRQ_PIN_N <= 6'h3E;
    NMI_PIN <= 1'b0;
    cyc(10);
    chk(REQ_VECTOR, `EIV_VEC_NMI);
    chk(REQ_ADDR, 16'h001C);
    chk(STANDBY_WAKE, 1'b1);
    ack_on <= 1'b1;
    cyc(6);
    ack_on <= 1'b0;
    cyc(2);
    chk(NMI_PENDING, 1'b0);
    chk(REQ_VECTOR, `EIV_VEC_PIN0);
    NMI_PIN <= 1'b1;
    cyc(10);
    chk(NMI_PENDING, 1'b0);
    wr(A_SY, 32'hFF);
    apb(1'b0, A_SY, 32'h0);
    chk(rd, 32'h01);
    NMI_PIN <= 1'b0;
    cyc(10);
    chk(NMI_PENDING, 1'b0);
    NMI_PIN <= 1'b1;
    cyc(10);
    chk(NMI_PENDING, 1'b1);
    $display("test nmi done");
  endtask
  task automatic end_of_test;
    $display("Counts: %0d checks, %0d mismatches", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ****************************************************************
  // Clock, stimulus sequence and watchdog.
  // ****************************************************************
  initial begin
    SYS_CLK = 1'b0;
    forever #50 SYS_CLK = ~SYS_CLK;
  end
  initial begin
    RST = 1'b1;
    HW_STANDBY = 1'b0;
    MODE_ADVANCED = 1'b1;
    NMI_PIN = 1'b1;
    IRQ_PIN_N = 6'h3F;
    INT_REQ = 27'h0;
    INT_EN = 27'h0;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 8'h00;
    PWDATA = 32'h0;
    ack_on = 1'b0;
    cyc(10);
    RST <= 1'b0;
    cyc(4);
    t_regs();
    t_gate();
    t_edges();
    t_prio();
    t_nmi();
    end_of_test();
  end
  initial begin
    cyc(20000);
    num_errors++;
    end_of_test();
  end
endmodule // eiv_top_bench
`default_nettype wire
